// *** verilog/msh_map.vh ***
// constants for the modbus slave request handler
// assumes a byte-framed request stream; included by the crc and handler files
`ifndef MSH_MAP_VH
`define MSH_MAP_VH

// ==========================================
// function codes and reply flags
`define MSH_FC_READ      8'h03
`define MSH_FC_WRITE     8'h10
`define MSH_FC_ERR_FLAG  8'h80

// ==========================================
// register addressing
`define MSH_REG_BASE     16'h0100
`define MSH_CAL_REG      16'h01AA
`define MSH_PARAM_LAST   16'h00E2
`define MSH_RD_CNT_MIN   16'h0002
`define MSH_RD_CNT_MAX   16'h007C
`define MSH_WR_CNT       16'h0002
`define MSH_WR_BCNT      8'h04

// ==========================================
// request body lengths (bytes after the address, before the crc) and buffer size (body plus crc)
`define MSH_RD_LEN       4'h5
`define MSH_WR_LEN       4'hA
`define MSH_BUF_LEN      4'hC

// ==========================================
// exception codes
`define MSH_EXC_FUNC     8'h01
`define MSH_EXC_ADDR     8'h02
`define MSH_EXC_VALUE    8'h03
`define MSH_EXC_FAIL     8'h04

// ==========================================
// calibration state floats and codes
`define MSH_F_MEASURE    32'h00000000
`define MSH_F_CYCLE      32'h3F800000
`define MSH_F_ZERO       32'h40000000
`define MSH_F_SPAN       32'h40400000
`define MSH_CAL_MEASURE  2'h0
`define MSH_CAL_CYCLE    2'h1
`define MSH_CAL_ZERO     2'h2
`define MSH_CAL_SPAN     2'h3

// ==========================================
// crc
`define MSH_CRC_INIT     16'hFFFF
`define MSH_CRC_POLY     16'hA001

`endif

// *** verilog/msh_crc16.v ***
// running modbus crc over a byte stream
// assumes clr and en are never high together
`timescale 1ns/1ns
`include "msh_map.vh"

module msh_crc16 (
	input  wire        clk,     // system clock
	input  wire        rst_n,   // async reset, active low
	input  wire        clr,     // restart crc
	input  wire        en,      // fold din in
	input  wire [7:0]  din,     // byte
	output reg  [15:0] crc_reg  // crc so far
);

	// ==========================================
	// byte step, reflected polynomial
	function [15:0] step;
		input [15:0] c;
		input [7:0]  d;
		integer      n;
		reg   [15:0] t;
		begin
			t = c ^ {8'h00, d};
			for (n = 0; n < 8; n = n + 1) begin
				if (t[0])
					t = (t >> 1) ^ `MSH_CRC_POLY;
				else
					t = t >> 1;
			end
			step = t;
		end
	endfunction

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			crc_reg <= `MSH_CRC_INIT;
		else if (clr)
			crc_reg <= `MSH_CRC_INIT;
		else if (en)
			crc_reg <= step(crc_reg, din);
	end

endmodule // msh_crc16

// *** verilog/msh_byte_order.v ***
// assembles four wire bytes into one ieee word
// assumes bytes are given in wire order, b0 first
`timescale 1ns/1ns

module msh_byte_order (
	input  wire [7:0]  b0,         // first byte on the wire
	input  wire [7:0]  b1,         // second byte
	input  wire [7:0]  b2,         // third byte
	input  wire [7:0]  b3,         // fourth byte
	input  wire        big_endian, // 1: msb byte sits last
	output wire [31:0] word        // assembled float
);

	// big setting puts the msb at the right end
	assign word = big_endian ? {b3, b2, b1, b0} : {b0, b1, b2, b3};

endmodule // msh_byte_order

// *** verilog/msh_modbus_slave.v ***
// modbus slave request handler: read holding and write multiple registers
// assumes a framer on the same clock delivers bytes and a frame-end pulse,
// and a parameter store answers value fetches by handshake
`timescale 1ns/1ns
`include "msh_map.vh"

// Behaviour
// - only function codes 3 and 16 are served
// - serial requests begin with address equal to slave id; tcp has none
// - serial frames end in modbus crc, msb first; tcp has no crc
// - start register is parameter number times two plus 256
// - floats use ieee format with selectable byte order
// - read reply: address, 3, register count, data bytes, crc
// - writes only set calibration state at register 426 count two
// - float 0,1,2,3 select measure, cycle, zero, span
// - write success echoes first six request bytes plus crc
// - error reply: address, function plus 128, exception code, crc
// - exception codes 1 to 3
module msh_modbus_slave (
	input  wire        clk,         // 100 mhz system clock
	input  wire        rst_n,       // async reset, active low
	input  wire [7:0]  slave_id,    // configured serial id
	input  wire        tcp_mode,    // 1: no address, no crc
	input  wire        big_endian,  // 1: float msb byte last on wire
	input  wire [7:0]  rx_data,     // request byte
	input  wire        rx_valid,    // request byte valid
	output wire        rx_ready,    // handler accepts bytes
	input  wire        rx_end,      // frame end pulse
	output reg  [7:0]  tx_data_reg, // reply byte
	output reg         tx_valid_reg,// reply byte valid
	output reg         tx_last_reg, // last byte of reply
	input  wire        tx_ready,    // sink takes byte
	output wire        val_req,     // value fetch request
	output wire [7:0]  val_idx,     // parameter number to fetch
	input  wire        val_ack,     // fetch done
	input  wire [31:0] val_data,    // fetched float
	output reg  [1:0]  cal_state_reg, // calibration state
	output reg         cal_wr_reg   // pulse on state write
);

	// ==========================================
	// states
	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_EVAL  = 3'h1;
	localparam [2:0] S_HDR   = 3'h2;
	localparam [2:0] S_FETCH = 3'h3;
	localparam [2:0] S_DATA  = 3'h4;
	localparam [2:0] S_CRC   = 3'h5;

	localparam [1:0] K_READ  = 2'h0;
	localparam [1:0] K_WRITE = 2'h1;
	localparam [1:0] K_ERR   = 2'h2;

	reg  [2:0]  state_reg;
	reg  [7:0]  buf_mem [0:11];
	reg  [3:0]  pos_reg;
	reg         got_addr_reg;
	reg         addr_ok_reg;
	reg         ovf_reg;
	reg  [15:0] crc_p1_reg;
	reg  [15:0] crc_p2_reg;
	reg  [1:0]  kind_reg;
	reg  [7:0]  fc_reg;
	reg  [7:0]  exc_reg;
	reg  [15:0] cnt_reg;
	reg  [7:0]  idx_reg;
	reg  [6:0]  left_reg;
	reg  [31:0] word_reg;
	reg  [2:0]  i_reg;
	reg  [1:0]  k_reg;
	reg  [7:0]  tx_byte;
	reg         last_now;

	wire        rx_take;
	wire [15:0] rx_crc;
	wire [15:0] tx_crc;
	wire        load;
	wire [31:0] wr_word;
	wire [7:0]  fc;
	wire [15:0] st;
	wire [15:0] cnt;
	wire [15:0] pidx;
	wire [15:0] plast;
	wire [3:0]  blen;
	wire        crc_ok;
	wire        sending;
	wire [2:0]  hdr_end;
	wire        tx_crc_en;

	assign rx_ready = (state_reg == S_IDLE);
	assign rx_take  = rx_valid & rx_ready;
	assign fc       = buf_mem[0];
	assign st       = {buf_mem[1], buf_mem[2]};
	assign cnt      = {buf_mem[3], buf_mem[4]};
	assign pidx     = (st - `MSH_REG_BASE) >> 1;
	// last value of a consecutive run
	assign plast    = pidx + (cnt >> 1) - 16'h0001;
	assign blen     = tcp_mode ? pos_reg : (pos_reg - 4'h2);
	// crc over all but the last two bytes, msb first
	assign crc_ok   = (pos_reg >= 4'h2) &&
	                  ({buf_mem[pos_reg - 4'h2], buf_mem[pos_reg - 4'h1]} == crc_p2_reg);

	// ==========================================
	// byte order and crc engines
	// write data assembled per byte order
	msh_byte_order u_order (
		.b0         (buf_mem[6]),
		.b1         (buf_mem[7]),
		.b2         (buf_mem[8]),
		.b3         (buf_mem[9]),
		.big_endian (big_endian),
		.word       (wr_word)
	);

	msh_crc16 u_rx_crc (
		.clk     (clk),
		.rst_n   (rst_n),
		.clr     (state_reg == S_EVAL),
		.en      (rx_take),
		.din     (rx_data),
		.crc_reg (rx_crc)
	);

	msh_crc16 u_tx_crc (
		.clk     (clk),
		.rst_n   (rst_n),
		.clr     (state_reg == S_EVAL),
		.en      (tx_crc_en),
		.din     (tx_byte),
		.crc_reg (tx_crc)
	);

	// ==========================================
	// receive side
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_reg      <= 4'h0;
			got_addr_reg <= 1'b0;
			addr_ok_reg  <= 1'b0;
			ovf_reg      <= 1'b0;
			crc_p1_reg   <= `MSH_CRC_INIT;
			crc_p2_reg   <= `MSH_CRC_INIT;
		end else if (state_reg == S_EVAL) begin
			pos_reg      <= 4'h0;
			got_addr_reg <= 1'b0;
			ovf_reg      <= 1'b0;
		end else if (rx_take) begin
			// history so the crc before the crc field is at hand
			crc_p1_reg <= rx_crc;
			crc_p2_reg <= crc_p1_reg;
			// first serial byte is the slave address
			if (!tcp_mode && !got_addr_reg) begin
				got_addr_reg <= 1'b1;
				addr_ok_reg  <= (rx_data == slave_id);
			end else if (pos_reg < `MSH_BUF_LEN) begin
				pos_reg <= pos_reg + 4'h1;
			end else begin
				ovf_reg <= 1'b1;
			end
		end
	end

	// buffer has no reset; pos_reg guards its use
	always @(posedge clk) begin
		if (rx_take && (tcp_mode || got_addr_reg) && (pos_reg < `MSH_BUF_LEN))
			buf_mem[pos_reg] <= rx_data;
	end

	// ==========================================
	// reply byte choice
	function [7:0] pick;
		input [31:0] w;
		input [1:0]  k;
		input        be;
		begin
			if (be)
				pick = w[8 * k +: 8];
			else
				pick = w[31 - 8 * k -: 8];
		end
	endfunction

	always @* begin
		tx_byte  = 8'h00;
		last_now = 1'b0;
		case (state_reg)
		S_HDR: begin
			if (i_reg == 3'h0)
				tx_byte = slave_id;
			else if (i_reg == 3'h1)
				tx_byte = fc_reg;
			else if (kind_reg == K_ERR)
				tx_byte = exc_reg;
			else if (kind_reg == K_READ)
				tx_byte = (i_reg == 3'h2) ? cnt_reg[15:8] : cnt_reg[7:0];
			else
				tx_byte = buf_mem[i_reg - 3'h1];
			last_now = tcp_mode && (i_reg == hdr_end) && (kind_reg != K_READ);
		end
		S_DATA: begin
			tx_byte  = pick(word_reg, k_reg, big_endian);
			last_now = tcp_mode && (k_reg == 2'h3) && (left_reg == 7'h01);
		end
		S_CRC: begin
			tx_byte  = (i_reg == 3'h0) ? tx_crc[15:8] : tx_crc[7:0];
			last_now = (i_reg != 3'h0);
		end
		default: begin
			tx_byte  = 8'h00;
			last_now = 1'b0;
		end
		endcase
	end

	// read header ends after count; echo ends at sixth byte
	// error header ends after exception code
	assign hdr_end   = (kind_reg == K_READ) ? 3'h3 :
	                   (kind_reg == K_WRITE) ? 3'h5 : 3'h2;
	assign sending   = (state_reg == S_HDR) || (state_reg == S_DATA) ||
	                   (state_reg == S_CRC);
	assign load      = sending && (!tx_valid_reg || tx_ready);
	assign tx_crc_en = load && (state_reg != S_CRC);
	assign val_req   = (state_reg == S_FETCH);
	assign val_idx   = idx_reg;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid_reg <= 1'b0;
			tx_data_reg  <= 8'h00;
			tx_last_reg  <= 1'b0;
		end else if (load) begin
			tx_valid_reg <= 1'b1;
			tx_data_reg  <= tx_byte;
			tx_last_reg  <= last_now;
		end else if (tx_ready) begin
			tx_valid_reg <= 1'b0;
			tx_last_reg  <= 1'b0;
		end
	end

	// ==========================================
	// control
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg     <= S_IDLE;
			kind_reg      <= K_ERR;
			fc_reg        <= 8'h00;
			exc_reg       <= 8'h00;
			cnt_reg       <= 16'h0000;
			idx_reg       <= 8'h00;
			left_reg      <= 7'h00;
			word_reg      <= 32'h00000000;
			i_reg         <= 3'h0;
			k_reg         <= 2'h0;
			cal_state_reg <= `MSH_CAL_MEASURE;
			cal_wr_reg    <= 1'b0;
		end else begin
			cal_wr_reg <= 1'b0;
			case (state_reg)
			S_IDLE: begin
				if (rx_ready && rx_end)
					state_reg <= S_EVAL;
			end
			S_EVAL: begin
				fc_reg   <= fc | `MSH_FC_ERR_FLAG;
				kind_reg <= K_ERR;
				cnt_reg  <= cnt;
				idx_reg  <= pidx[7:0];
				left_reg <= cnt[7:1];
				i_reg    <= tcp_mode ? 3'h1 : 3'h0;
				state_reg <= S_HDR;
				// drop foreign, corrupt or malformed frames
				if (ovf_reg || blen == 4'h0 || pos_reg < (tcp_mode ? 4'h1 : 4'h3) ||
				    (!tcp_mode && (!addr_ok_reg || !crc_ok))) begin
					state_reg <= S_IDLE;
				end else if (fc == `MSH_FC_READ) begin
					if (blen != `MSH_RD_LEN)
						state_reg <= S_IDLE;
					else if (cnt < `MSH_RD_CNT_MIN || cnt > `MSH_RD_CNT_MAX || cnt[0])
						exc_reg <= `MSH_EXC_VALUE;
					// start must map onto a parameter run
					else if (st < `MSH_REG_BASE || st[0] || plast > `MSH_PARAM_LAST)
						exc_reg <= `MSH_EXC_ADDR;
					else begin
						kind_reg <= K_READ;
						fc_reg   <= `MSH_FC_READ;
					end
				end else if (fc == `MSH_FC_WRITE) begin
					if (blen != `MSH_WR_LEN)
						state_reg <= S_IDLE;
					else if (cnt != `MSH_WR_CNT || buf_mem[5] != `MSH_WR_BCNT)
						exc_reg <= `MSH_EXC_VALUE;
					// only the calibration register is writable
					else if (st != `MSH_CAL_REG)
						exc_reg <= `MSH_EXC_ADDR;
					else begin
						kind_reg   <= K_WRITE;
						fc_reg     <= `MSH_FC_WRITE;
						cal_wr_reg <= 1'b1;
						case (wr_word)
						`MSH_F_MEASURE: cal_state_reg <= `MSH_CAL_MEASURE;
						`MSH_F_CYCLE:   cal_state_reg <= `MSH_CAL_CYCLE;
						`MSH_F_ZERO:    cal_state_reg <= `MSH_CAL_ZERO;
						`MSH_F_SPAN:    cal_state_reg <= `MSH_CAL_SPAN;
						default: begin
							kind_reg   <= K_ERR;
							fc_reg     <= fc | `MSH_FC_ERR_FLAG;
							exc_reg    <= `MSH_EXC_VALUE;
							cal_wr_reg <= 1'b0;
						end
						endcase
					end
				end else begin
					exc_reg <= `MSH_EXC_FUNC;
				end
			end
			S_HDR: begin
				if (load) begin
					if (i_reg != hdr_end)
						i_reg <= i_reg + 3'h1;
					else if (kind_reg == K_READ)
						state_reg <= S_FETCH;
					else begin
						i_reg     <= 3'h0;
						state_reg <= tcp_mode ? S_IDLE : S_CRC;
					end
				end
			end
			S_FETCH: begin
				if (val_ack) begin
					word_reg  <= val_data;
					k_reg     <= 2'h0;
					state_reg <= S_DATA;
				end
			end
			S_DATA: begin
				// four bytes per value in chosen order
				if (load) begin
					k_reg <= k_reg + 2'h1;
					if (k_reg == 2'h3) begin
						left_reg <= left_reg - 7'h01;
						idx_reg  <= idx_reg + 8'h01;
						i_reg    <= 3'h0;
						if (left_reg != 7'h01)
							state_reg <= S_FETCH;
						else
							state_reg <= tcp_mode ? S_IDLE : S_CRC;
					end
				end
			end
			S_CRC: begin
				if (load) begin
					i_reg <= 3'h1;
					if (i_reg != 3'h0)
						state_reg <= S_IDLE;
				end
			end
			default: state_reg <= S_IDLE;
			endcase
		end
	end

endmodule // msh_modbus_slave

// *** verilog/msh_modbus_slave_fix.v ***
// holds no logic; the request handler lives in msh_modbus_slave.v

// *** testbench/msh_store_model.sv ***
// parameter store model: answers value fetches after 0 to 3 idle cycles
// assumes the handler holds val_req and val_idx until acknowledged
`timescale 1ns/1ns
module msh_store_model (
	input  wire        clk,      // clock
	input  wire        rst_n,    // reset, active low
	input  wire        val_req,  // fetch request
	input  wire [7:0]  val_idx,  // parameter number
	output reg         val_ack,  // fetch done pulse
	output reg  [31:0] val_data  // fetched word
);
	reg [1:0] wait_reg;
	// =====
	// data word scrambles when not acked so stale values never pass
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			val_ack <= 1'b0;
			val_data <= 32'h0;
			wait_reg <= 2'h0;
		end else if (val_req && !val_ack && wait_reg == 2'h0) begin
			val_ack <= 1'b1;
			val_data <= {val_idx, ~val_idx, 8'hA5, val_idx ^ 8'h3C};
			wait_reg <= 2'($urandom_range(3));
		end else begin
			val_ack <= 1'b0;
			val_data <= ~val_data;
			if (val_req && wait_reg != 2'h0)
				wait_reg <= wait_reg - 2'h1;
		end
	end
endmodule // msh_store_model

// *** testbench/msh_modbus_slave_chk.sv ***
// timing checks on the request handler ports
// assumes one clock domain and an active-low async reset
`timescale 1ns/1ns
module msh_modbus_slave_chk (
	input wire       clk,           // clock
	input wire       rst_n,         // reset, active low
	input wire       rx_end,        // frame end
	input wire       rx_ready,      // accepting bytes
	input wire [7:0] tx_data_reg,   // reply byte
	input wire       tx_valid_reg,  // reply valid
	input wire       tx_last_reg,   // last reply byte
	input wire       tx_ready,      // sink ready
	input wire       val_req,       // fetch request
	input wire [7:0] val_idx,       // fetch index
	input wire       val_ack,       // fetch done
	input wire [1:0] cal_state_reg, // calibration state
	input wire       cal_wr_reg     // state write pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// =====
	busy_after_end_a: assert property (rx_end && rx_ready |=> !rx_ready)
		else $error("bytes accepted right after frame end");
	first_byte_a: assert property ($fell(rx_ready) ##1 !rx_ready |-> ##[0:2] tx_valid_reg)
		else $error("reply did not start in time");
	hold_reply_a: assert property (tx_valid_reg && !tx_ready |=>
		tx_valid_reg && $stable(tx_data_reg) && $stable(tx_last_reg))
		else $error("reply byte changed before taken");
	last_ends_a: assert property (tx_valid_reg && tx_ready && tx_last_reg |=> !tx_valid_reg)
		else $error("byte after last reply byte");
	fetch_hold_a: assert property (val_req && !val_ack |=> val_req && $stable(val_idx))
		else $error("fetch request dropped early");
	fetch_busy_a: assert property (val_req |-> !rx_ready)
		else $error("fetch while idle");
	tx_busy_a: assert property (tx_valid_reg && !tx_last_reg |-> !rx_ready)
		else $error("idle during reply");
	cal_pulse_a: assert property (cal_wr_reg |=> !cal_wr_reg)
		else $error("state write pulse too long");
	cal_cause_a: assert property ($changed(cal_state_reg) |-> cal_wr_reg && !rx_ready)
		else $error("state changed without write");
endmodule // msh_modbus_slave_chk

bind msh_modbus_slave msh_modbus_slave_chk chk (.clk(clk), .rst_n(rst_n), .rx_end(rx_end),
	.rx_ready(rx_ready), .tx_data_reg(tx_data_reg), .tx_valid_reg(tx_valid_reg),
	.tx_last_reg(tx_last_reg), .tx_ready(tx_ready), .val_req(val_req), .val_idx(val_idx),
	.val_ack(val_ack), .cal_state_reg(cal_state_reg), .cal_wr_reg(cal_wr_reg));

// *** testbench/tb_modbus_slave_command_handler.sv ***
// self-checking bench: acts as the remote master, store model answers fetches
// assumes the handler header and constants from the verilog folder
`timescale 1ns/1ns
module tb_modbus_slave_command_handler;
	reg		clk, rst_n, tcp_mode, big_endian, rx_valid, rx_end, tx_ready;
	reg	[7:0]	slave_id, rx_data;
	wire		rx_ready, tx_valid_reg, tx_last_reg, val_req, val_ack, cal_wr_reg;
	wire	[7:0]	tx_data_reg, val_idx;
	wire	[31:0]	val_data;
	wire	[1:0]	cal_state_reg;
	integer		num_errors, tests_run, cyc, i, k, r, n, p, s;
	reg	[31:0]	w;
	logic	[7:0]	req[$], exp_q[$], got[$];
	logic	[31:0]	cal_f[4] = '{32'h0, 32'h3F800000, 32'h40000000, 32'h40400000};

	msh_modbus_slave dut (.clk(clk), .rst_n(rst_n), .slave_id(slave_id),
		.tcp_mode(tcp_mode), .big_endian(big_endian), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_end(rx_end),
		.tx_data_reg(tx_data_reg), .tx_valid_reg(tx_valid_reg), .tx_last_reg(tx_last_reg),
		.tx_ready(tx_ready), .val_req(val_req), .val_idx(val_idx), .val_ack(val_ack),
		.val_data(val_data), .cal_state_reg(cal_state_reg), .cal_wr_reg(cal_wr_reg));
	msh_store_model store (.clk(clk), .rst_n(rst_n), .val_req(val_req),
		.val_idx(val_idx), .val_ack(val_ack), .val_data(val_data));

	// =====
	function automatic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[j]) begin
			c = c ^ {8'h00, q[j]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		crc16 = c;
	endfunction
	function automatic [31:0] val_word(input logic [7:0] x);
		val_word = {x, ~x, 8'hA5, x ^ 8'h3C};
	endfunction
	task chk(input logic [15:0] g, input logic [15:0] e);
		tests_run = tests_run + 1;
		if (g !== e) begin
			num_errors = num_errors + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// bad[0] spoils the crc, bad[1] the address
	task send(input logic [7:0] b[$], input logic [1:0] bad);
		logic [15:0] c;
		if (!tcp_mode) begin
			b.push_front(slave_id ^ {7'h0, bad[1]});
			c = crc16(b) ^ {15'h0, bad[0]};
			b.push_back(c[15:8]);
			b.push_back(c[7:0]);
		end
		foreach (b[j]) begin
			@(negedge clk);
			while (!rx_ready) @(negedge clk);
			rx_data = b[j];
			rx_valid = 1'b1;
			rx_end = (j == b.size() - 1);
		end
		@(negedge clk);
		rx_valid = 1'b0;
		rx_end = 1'b0;
	endtask
	// sink stalls at random to exercise the hold
	task reply(input logic [7:0] e[$]);
		logic [15:0] c;
		if (!tcp_mode) begin
			e.push_front(slave_id);
			c = crc16(e);
			e.push_back(c[15:8]);
			e.push_back(c[7:0]);
		end
		got = {};
		k = 0;
		while (k == 0) begin
			@(negedge clk);
			tx_ready = ($urandom_range(3) != 0);
			if (tx_valid_reg && tx_ready) begin
				got.push_back(tx_data_reg);
				k = tx_last_reg;
			end
		end
		chk(16'(got.size()), 16'(e.size()));
		foreach (e[j]) chk(got[j], e[j]);
	endtask
	task silent;
		k = 0;
		repeat (12) begin
			@(negedge clk);
			if (tx_valid_reg !== 1'b0) k = 1;
		end
		chk(16'(k), 16'h0000);
	endtask
	task summarize;
		if (num_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// =====
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			summarize;
		end
	end
	initial begin
		rst_n = 1'b0;
		tcp_mode = 1'b1;
		big_endian = 1'b0;
		rx_valid = 1'b0;
		rx_end = 1'b0;
		tx_ready = 1'b0;
		rx_data = 8'h00;
		num_errors = 0;
		tests_run = 0;
		cyc = 0;
		i = $urandom(32'h0822);
		slave_id = $urandom_range(255);
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		// reads, last one the 62-value maximum
		for (r = 0; r < 6; r = r + 1) begin
			tcp_mode = r[0];
			big_endian = r[1];
			n = (r == 5) ? 62 : $urandom_range(4, 1);
			p = $urandom_range(227 - n, 0);
			s = p * 2 + 256;
			req = {8'h03, s[15:8], s[7:0], 8'h00, 8'(n * 2)};
			exp_q = {8'h03, 8'h00, 8'(n * 2)};
			for (i = 0; i < n; i = i + 1) begin
				w = val_word(8'(p + i));
				for (k = 0; k < 4; k = k + 1)
					exp_q.push_back(big_endian ? w[8*k +: 8] : w[31-8*k -: 8]);
			end
			send(req, 2'h0);
			reply(exp_q);
		end
		// corrupted and misaddressed serial frames
		tcp_mode = 1'b0;
		send(req, 2'h1);
		silent;
		send(req, 2'h2);
		silent;
		// all four states, the reset state last
		for (r = 1; r < 5; r = r + 1) begin
			big_endian = r[0];
			w = cal_f[r[1:0]];
			req = {8'h10, 8'h01, 8'hAA, 8'h00, 8'h02, 8'h04};
			for (k = 0; k < 4; k = k + 1)
				req.push_back(big_endian ? w[8*k +: 8] : w[31-8*k -: 8]);
			send(req, 2'h0);
			reply(req[0:4]);
			chk({14'h0, cal_state_reg}, {14'h0, r[1:0]});
		end
		for (r = 0; r < 9; r = r + 1) begin
			tcp_mode = r[0];
			case (r)
			0: req = {8'h04, 8'h01, 8'h00, 8'h00, 8'h02};
			1: req = {8'h03, 8'h01, 8'h00, 8'h00, 8'h03};
			2: req = {8'h03, 8'h01, 8'h00, 8'h00, 8'h7E};
			3: req = {8'h03, 8'h01, 8'h01, 8'h00, 8'h02};
			4: req = {8'h10, 8'h01, 8'hAA, 8'h00, 8'h03, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
			5: req = {8'h10, 8'h01, 8'hAA, 8'h00, 8'h02, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
			6: req = {8'h10, 8'h01, 8'hAC, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
			7: req = {8'h10, 8'h01, 8'hAA, 8'h00, 8'h02, 8'h04, 8'h40, 8'h80, 8'h00, 8'h00};
			default: req = {8'h03, 8'h02, 8'hC6, 8'h00, 8'h02};
			endcase
			k = (r == 0) ? 1 : (r == 3 || r == 6 || r == 8) ? 2 : 3;
			exp_q = {req[0] | 8'h80, 8'(k)};
			send(req, 2'h0);
			reply(exp_q);
		end
		chk({14'h0, cal_state_reg}, 16'h0000);
		summarize;
	end
endmodule // tb_modbus_slave_command_handler
